// >>> rtl/rhb_pkg.sv
// rhb_pkg: constants, time carrier type and byte codecs of the rtc core
// assumes one 100 MHz clock and a 32.768 kHz tick arriving on a pin
package rhb_pkg;
   typedef struct packed
   {
      logic [7:0] year;
      logic [7:0] mon;
      logic [7:0] mday;
      logic [7:0] wday;
      logic [7:0] hour;
      logic [7:0] min;
      logic [7:0] sec;
   } rhb_time_type;

   localparam int NUM_CLK_BYTES = 14;
   localparam int NUM_RAM_BYTES = 114;
   localparam int NUM_USER_BYTES = 10;
   localparam logic [6:0] ADDR_SEC = 7'h00;
   localparam logic [6:0] ADDR_MIN = 7'h02;
   localparam logic [6:0] ADDR_HOUR = 7'h04;
   localparam logic [6:0] ADDR_WDAY = 7'h06;
   localparam logic [6:0] ADDR_MDAY = 7'h07;
   localparam logic [6:0] ADDR_MON = 7'h08;
   localparam logic [6:0] ADDR_YEAR = 7'h09;
   localparam logic [6:0] ADDR_A = 7'h0A;
   localparam logic [6:0] ADDR_B = 7'h0B;
   localparam logic [6:0] ADDR_C = 7'h0C;
   localparam logic [6:0] ADDR_D = 7'h0D;
   localparam logic [9:0] TIME_BYTE_MASK = 10'h3D5;
   localparam int B_FREEZE = 7;
   localparam int B_PIE = 6;
   localparam int B_AIE = 5;
   localparam int B_UIE = 4;
   localparam int B_WAVE = 3;
   localparam int B_BIN = 2;
   localparam int B_H24 = 1;
   localparam logic [7:0] B_PIN_CLR = 8'h78;
   localparam logic [7:0] REG_A_RST = 8'h26;
   localparam logic [7:0] REG_B_RST = 8'h02;
   localparam logic [7:0] REG_D_VAL = 8'h80;
   localparam logic [2:0] OSC_RUN = 3'h2;
   localparam logic [1:0] DONT_CARE = 2'h3;
   localparam rhb_time_type TIME_RST = 56'h00_01_01_01_00_00_00;
   localparam int DIV_W = 15;
   localparam int TICK_HZ = 32768;
   localparam int LEAD_US = 244;
   localparam int LEAD_TICKS = (LEAD_US * TICK_HZ + 999999) / 1000000;
   localparam int UPD_US = 2000;
   localparam int UPD_TICKS = (UPD_US * TICK_HZ) / 1000000;

   function automatic logic [7:0] rhb_enc(input logic [7:0] v,
                                          input logic bin);
      logic [7:0] t;
      logic [7:0] o;
      t = v / 8'h0A;
      o = v % 8'h0A;
      return bin ? v : {t[3:0], o[3:0]};
   endfunction

   function automatic logic [7:0] rhb_dec(input logic [7:0] b,
                                          input logic bin);
      return bin ? b : 8'(8'(b[7:4]) * 8'h0A + 8'(b[3:0]));
   endfunction

   function automatic logic [7:0] rhb_henc(input logic [7:0] h,
                                           input logic bin,
                                           input logic h24);
      logic [7:0] hh;
      logic [7:0] e;
      hh = (h == 8'h00) ? 8'h0C : (h > 8'h0C) ? 8'(h - 8'h0C) : h;
      e = rhb_enc(hh, bin);
      return h24 ? rhb_enc(h, bin) : {h > 8'h0B, e[6:0]};
   endfunction

   function automatic logic [7:0] rhb_hdec(input logic [7:0] b,
                                           input logic bin,
                                           input logic h24);
      logic [7:0] hh;
      hh = rhb_dec({1'b0, b[6:0]}, bin);
      hh = (hh == 8'h0C) ? 8'h00 : hh;
      return h24 ? rhb_dec(b, bin) : 8'(hh + (b[7] ? 8'h0C : 8'h00));
   endfunction
endpackage

// >>> rtl/rhb_sync2.sv
// rhb_sync2: two-flop level synchroniser for a bundle of pins
// assumes each bit is a slow level; bundles are not coherent words
`timescale 1ns/1ns
module rhb_sync2 #(parameter int W = 1)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // pin levels in, synchronised levels out
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         meta_q <= '0;
         q <= '0;
      end
      else
      begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule

// >>> rtl/rhb_cal_step.sv
// rhb_cal_step: next second of the binary internal calendar
// assumes fields hold legal binary values; 24-hour internal form
`timescale 1ns/1ns
module rhb_cal_step
(
   // current and next time
   input rhb_pkg::rhb_time_type cur,
   output rhb_pkg::rhb_time_type nxt
);
   logic [7:0] last_day;

   always_comb
   begin
      unique case (cur.mon)
         8'h04, 8'h06, 8'h09, 8'h0B: last_day = 8'h1E;
         8'h02: last_day = (cur.year[1:0] == 2'h0) ? 8'h1D : 8'h1C;
         default: last_day = 8'h1F;
      endcase
   end

   // each field carries only when all lower fields wrap
   always_comb
   begin
      nxt = cur;
      nxt.sec = 8'(cur.sec + 8'h01);
      if (cur.sec >= 8'h3B)
      begin
         nxt.sec = 8'h00;
         nxt.min = 8'(cur.min + 8'h01);
         if (cur.min >= 8'h3B)
         begin
            nxt.min = 8'h00;
            nxt.hour = 8'(cur.hour + 8'h01);
            if (cur.hour >= 8'h17)
            begin
               nxt.hour = 8'h00;
               nxt.wday = (cur.wday >= 8'h07) ? 8'h01 : 8'(cur.wday + 8'h01);
               nxt.mday = 8'(cur.mday + 8'h01);
               if (cur.mday >= last_day)
               begin
                  nxt.mday = 8'h01;
                  nxt.mon = 8'(cur.mon + 8'h01);
                  if (cur.mon >= 8'h0C)
                  begin
                     nxt.mon = 8'h01;
                     nxt.year = (cur.year >= 8'h63) ? 8'h00 :
                                8'(cur.year + 8'h01);
                  end
               end
            end
         end
      end
   end
endmodule

// >>> rtl/rhb_core.sv
// rhb_core: host bus, flags, interrupt, wave output and update cycle
// assumes all pins but ram_ce_in_n are asynchronous and pass the two-flop synchroniser
`timescale 1ns/1ns
module rhb_core #(parameter int NUM_RAM = rhb_pkg::NUM_RAM_BYTES)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // multiplexed host bus
   input wire logic [7:0] mux_addr_data_in,
   output logic [7:0] mux_addr_data_out,
   output logic mux_addr_data_oe,
   input wire logic addr_strobe,
   input wire logic data_strobe,
   input wire logic rw_strobe,
   input wire logic chip_sel_n,
   input wire logic bus_style_select,
   // device reset pin and open-drain interrupt
   input wire logic reset_pin_n,
   output logic irq_out,
   output logic irq_oe,
   // time base and square wave
   input wire logic osc_tick,
   output logic wave_out,
   // external ram enable
   input wire logic ram_power_good,
   input wire logic ram_ce_in_n,
   output logic ram_ce_out_n
);
   typedef enum logic [2:0]
   {
      UPD_IDLE = 3'b001,
      UPD_LEAD = 3'b010,
      UPD_BUSY = 3'b100
   } rhb_upd_type;

   logic [15:0] pin_s;
   logic [7:0] ad_s;
   logic as_s, ds_s, rw_s, cs_n_s, style_s, rpin_n_s, tick_s, pgood_s;
   logic as_p_q, ds_p_q, rw_p_q, tick_p_q;
   logic as_fall, tick, sel;
   logic rd_act, rd_start, wr_ev, rd_go, wr_go, drive, c_clear;
   logic [6:0] addr_q;
   logic [6:0] ram_idx;
   logic [7:0] rd_mux, rd_q;
   logic [7:0] reg_a_q, reg_b_q;
   logic pf_q, af_q, uf_q, irqf_q, irq_any;
   logic ev_pf, ev_af, ev_uf;
   logic [7:0] ram_q [NUM_RAM];
   logic [7:0] user_q [rhb_pkg::NUM_USER_BYTES];
   logic [7:0] nfmt [rhb_pkg::NUM_USER_BYTES];
   rhb_pkg::rhb_time_type time_q, nxt_t;
   logic [rhb_pkg::DIV_W-1:0] div_q;
   logic [7:0] upd_cnt_q;
   rhb_upd_type upd_q;
   logic run, hold, wrap, upd_end, update_pending, inh, bin, h24, alarm_hit;
   logic [3:0] rate, tap_idx;
   logic tap, tap_on, tap_p_q, wave_q;

   rhb_sync2 #(.W(16)) u_sync
   (
      .clk(clk),
      .rst(rst),
      .d({mux_addr_data_in, addr_strobe, data_strobe, rw_strobe,
          chip_sel_n, bus_style_select, reset_pin_n, osc_tick,
          ram_power_good}),
      .q(pin_s)
   );

   assign {ad_s, as_s, ds_s, rw_s, cs_n_s, style_s, rpin_n_s, tick_s,
           pgood_s} = pin_s;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         as_p_q <= 1'b0;
         ds_p_q <= 1'b0;
         rw_p_q <= 1'b0;
         tick_p_q <= 1'b0;
      end
      else
      begin
         as_p_q <= as_s;
         ds_p_q <= ds_s;
         rw_p_q <= rw_s;
         tick_p_q <= tick_s;
      end
   end

   assign as_fall = as_p_q & ~as_s;
   assign tick = ~tick_p_q & tick_s;
   assign inh = reg_b_q[rhb_pkg::B_FREEZE];
   assign bin = reg_b_q[rhb_pkg::B_BIN];
   assign h24 = reg_b_q[rhb_pkg::B_H24];

   // address latch runs even while deselected
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         addr_q <= 7'h00;
      else if (as_fall)
         addr_q <= ad_s[6:0];
   end

   // a held-low reset pin or bad power refuses every access
   assign sel = ~cs_n_s & rpin_n_s & pgood_s;

   always_comb
   begin
      if (style_s)
      begin
         rd_act = ds_s & rw_s;
         rd_start = ~ds_p_q & ds_s & rw_s;
         wr_ev = ds_p_q & ~ds_s & ~rw_s;
      end
      else
      begin
         rd_act = ~ds_s;
         rd_start = ds_p_q & ~ds_s;
         wr_ev = ~rw_p_q & rw_s;
      end
   end

   assign rd_go = rd_start & sel;
   assign wr_go = wr_ev & sel;
   assign drive = rd_act & sel;
   assign c_clear = rd_go & (addr_q == rhb_pkg::ADDR_C);
   assign mux_addr_data_oe = drive;
   assign mux_addr_data_out = rd_q;
   assign ram_idx = 7'(addr_q - 7'(rhb_pkg::NUM_CLK_BYTES));

   always_comb
   begin
      if (addr_q < 7'(rhb_pkg::NUM_USER_BYTES))
         rd_mux = user_q[addr_q[3:0]];
      else if (addr_q == rhb_pkg::ADDR_A)
         rd_mux = {update_pending, reg_a_q[6:0]};
      else if (addr_q == rhb_pkg::ADDR_B)
         rd_mux = reg_b_q;
      else if (addr_q == rhb_pkg::ADDR_C)
         rd_mux = {irqf_q, pf_q, af_q, uf_q, 4'h0};
      else if (addr_q == rhb_pkg::ADDR_D)
         rd_mux = rhb_pkg::REG_D_VAL;
      else
         rd_mux = ram_q[ram_idx];
   end

   // frozen while driving, so a flag clear cannot change the byte
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         rd_q <= 8'h00;
      else if (!drive)
         rd_q <= rd_mux;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         reg_a_q <= rhb_pkg::REG_A_RST;
      else if (wr_go && addr_q == rhb_pkg::ADDR_A)
         reg_a_q <= {1'b0, ad_s[6:0]};
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         reg_b_q <= rhb_pkg::REG_B_RST;
      else if (!rpin_n_s)
         reg_b_q <= reg_b_q & ~rhb_pkg::B_PIN_CLR;
      else if (wr_go && addr_q == rhb_pkg::ADDR_B)
         reg_b_q <= ad_s;
   end

   // storage bytes carry no reset: contents are the user's
   always_ff @(posedge clk)
   begin
      if (wr_go && addr_q >= 7'(rhb_pkg::NUM_CLK_BYTES))
         ram_q[ram_idx] <= ad_s;
   end

   assign irq_any = (pf_q & reg_b_q[rhb_pkg::B_PIE]) |
                    (af_q & reg_b_q[rhb_pkg::B_AIE]) |
                    (uf_q & reg_b_q[rhb_pkg::B_UIE] & ~inh);

   // an event in the clearing cycle survives in pf_q, af_q and uf_q: set wins; for irqf_q clear wins
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pf_q <= 1'b0;
         af_q <= 1'b0;
         uf_q <= 1'b0;
         irqf_q <= 1'b0;
      end
      else if (!rpin_n_s)
      begin
         pf_q <= 1'b0;
         af_q <= 1'b0;
         uf_q <= 1'b0;
         irqf_q <= 1'b0;
      end
      else
      begin
         pf_q <= ev_pf | (pf_q & ~c_clear);
         af_q <= ev_af | (af_q & ~c_clear);
         uf_q <= ev_uf | (uf_q & ~c_clear);
         irqf_q <= ~c_clear & (irqf_q | irq_any);
      end
   end

   assign irq_out = 1'b0;
   assign irq_oe = irqf_q & rpin_n_s;

   // divider: 010 runs it, 11x holds it cleared, else stopped
   assign run = reg_a_q[6:4] == rhb_pkg::OSC_RUN;
   assign hold = reg_a_q[6:5] == 2'h3;
   assign wrap = run & tick & (div_q == '1);

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         div_q <= '0;
      else if (hold)
         div_q <= '0;
      else if (run && tick)
         div_q <= div_q + 1'b1;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         upd_q <= UPD_IDLE;
         upd_cnt_q <= 8'h00;
      end
      else if (!run)
         upd_q <= UPD_IDLE;
      else
      begin
         unique case (upd_q)
            UPD_IDLE:
               if (tick && div_q == rhb_pkg::DIV_W'(2 ** rhb_pkg::DIV_W - 1
                   - rhb_pkg::LEAD_TICKS))
                  upd_q <= UPD_LEAD;
            UPD_LEAD:
               if (wrap)
               begin
                  upd_q <= UPD_BUSY;
                  upd_cnt_q <= 8'h00;
               end
            UPD_BUSY:
               if (upd_end)
                  upd_q <= UPD_IDLE;
               else if (tick)
                  upd_cnt_q <= 8'(upd_cnt_q + 8'h01);
         endcase
      end
   end

   assign upd_end = (upd_q == UPD_BUSY) & run & tick &
                    (upd_cnt_q == 8'(rhb_pkg::UPD_TICKS - 1));
   assign update_pending = upd_q != UPD_IDLE;
   assign ev_uf = upd_end;

   rhb_cal_step u_cal
   (
      .cur(time_q),
      .nxt(nxt_t)
   );

   // internal copy in binary 24-hour form; host writes decoded
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         time_q <= rhb_pkg::TIME_RST;
      else if (upd_end)
         time_q <= nxt_t;
      else if (wr_go)
      begin
         case (addr_q)
            rhb_pkg::ADDR_SEC: time_q.sec <= rhb_pkg::rhb_dec(ad_s, bin);
            rhb_pkg::ADDR_MIN: time_q.min <= rhb_pkg::rhb_dec(ad_s, bin);
            rhb_pkg::ADDR_HOUR:
               time_q.hour <= rhb_pkg::rhb_hdec(ad_s, bin, h24);
            rhb_pkg::ADDR_WDAY: time_q.wday <= rhb_pkg::rhb_dec(ad_s, bin);
            rhb_pkg::ADDR_MDAY: time_q.mday <= rhb_pkg::rhb_dec(ad_s, bin);
            rhb_pkg::ADDR_MON: time_q.mon <= rhb_pkg::rhb_dec(ad_s, bin);
            rhb_pkg::ADDR_YEAR: time_q.year <= rhb_pkg::rhb_dec(ad_s, bin);
            default: ;
         endcase
      end
   end

   always_comb
   begin
      nfmt = user_q;
      nfmt[0] = rhb_pkg::rhb_enc(nxt_t.sec, bin);
      nfmt[2] = rhb_pkg::rhb_enc(nxt_t.min, bin);
      nfmt[4] = rhb_pkg::rhb_henc(nxt_t.hour, bin, h24);
      nfmt[6] = rhb_pkg::rhb_enc(nxt_t.wday, bin);
      nfmt[7] = rhb_pkg::rhb_enc(nxt_t.mday, bin);
      nfmt[8] = rhb_pkg::rhb_enc(nxt_t.mon, bin);
      nfmt[9] = rhb_pkg::rhb_enc(nxt_t.year, bin);
   end

   // a host write wins over the copy for that one byte
   for (genvar gi = 0; gi < rhb_pkg::NUM_USER_BYTES; gi++)
   begin : g_user
      always_ff @(posedge clk or posedge rst)
      begin
         if (rst)
            user_q[gi] <= 8'h00;
         else if (wr_go && addr_q == 7'(gi))
            user_q[gi] <= ad_s;
         else if (upd_end && !inh && rhb_pkg::TIME_BYTE_MASK[gi])
            user_q[gi] <= nfmt[gi];
      end
   end

   // alarm compares formatted bytes, so it follows the format bits
   always_comb
   begin
      alarm_hit = 1'b1;
      for (int k = 0; k < 3; k++)
      begin
         if (user_q[2 * k + 1][7:6] != rhb_pkg::DONT_CARE &&
             user_q[2 * k + 1] != nfmt[2 * k])
            alarm_hit = 1'b0;
      end
   end

   assign ev_af = upd_end & alarm_hit;

   assign rate = reg_a_q[3:0];
   assign tap_on = rate != 4'h0;
   assign tap_idx = (rate == 4'h1) ? 4'h6 : (rate == 4'h2) ? 4'h7 :
                    4'(rate - 4'h2);
   assign tap = div_q[tap_idx];
   assign ev_pf = tap_on & tap_p_q & ~tap;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         tap_p_q <= 1'b0;
         wave_q <= 1'b0;
      end
      else
      begin
         tap_p_q <= tap;
         wave_q <= reg_b_q[rhb_pkg::B_WAVE] & tap_on & tap;
      end
   end

   assign wave_out = wave_q;

   // pass-through kept combinational for the short enable path
   assign ram_ce_out_n = pgood_s ? ram_ce_in_n : 1'b1;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence s_ds_rise;
      style_s && !ds_p_q && ds_s && rw_s && sel;
   endsequence

   sequence s_upd_end;
      upd_end && !inh && !wr_go;
   endsequence

   a_addr_latch:
      assert property (as_p_q && !as_s |=> addr_q == $past(ad_s[6:0]))
      else $error("address not latched on strobe fall");
   a_quiet_desel:
      assert property (cs_n_s |-> !mux_addr_data_oe)
      else $error("bus driven while deselected");
   a_sep_read:
      assert property (!style_s && ds_p_q && !ds_s && sel
                       |-> mux_addr_data_oe)
      else $error("separate style read not driven");
   a_dir_read:
      assert property (s_ds_rise |-> mux_addr_data_oe ##1
                       (mux_addr_data_out == $past(mux_addr_data_out)))
      else $error("direction style read data unstable");
   a_write_b:
      assert property (wr_go && addr_q == rhb_pkg::ADDR_B
                       |=> reg_b_q == $past(ad_s))
      else $error("write data not captured");
   a_irq_assert:
      assert property (irq_any && !c_clear && rpin_n_s ##1 rpin_n_s
                       |-> irq_oe)
      else $error("interrupt not asserted");
   a_irq_release:
      assert property (c_clear |=> !irq_oe && !irqf_q)
      else $error("flag read did not release interrupt");
   a_pin_reset:
      assert property (!rpin_n_s [*2] |-> !irq_oe && !mux_addr_data_oe
                       && !pf_q && !uf_q)
      else $error("reset pin not honoured");
   a_wave_off:
      assert property (!reg_b_q[rhb_pkg::B_WAVE] |=> !wave_out)
      else $error("wave output not held low");
   a_wave_tap:
      assert property (reg_b_q[rhb_pkg::B_WAVE] && tap_on
                       |=> wave_out == $past(tap))
      else $error("wave output not following tap");
   a_ram_ce:
      assert property (pgood_s |-> ram_ce_out_n == ram_ce_in_n)
      else $error("ram enable not passed through");
   a_update_done:
      assert property (upd_end && rpin_n_s |=> !update_pending && uf_q)
      else $error("update end did not clear pending and set done");
   a_user_copy:
      assert property (s_upd_end |=> user_q[0] == $past(nfmt[0])
                       && time_q == $past(nxt_t))
      else $error("user copy not refreshed at update end");
   a_user_frozen:
      assert property (inh && !wr_go |=> $stable(user_q[0]))
      else $error("frozen user copy changed");
   a_uf_gated:
      assert property (inh && !pf_q && !af_q && !irqf_q && !c_clear
                       |=> !irqf_q)
      else $error("update interrupt raised while frozen");
endmodule

// >>> bench/rhb_host.sv
// rhb_host: host processor model driving the multiplexed strobe bus
// assumes the device samples every pin through two flops
`timescale 1ns/1ns
module rhb_host
(
   // clock and bus style
   input wire logic clk,
   input wire logic style,
   // shared wires and device drive
   output logic [7:0] bus,
   input wire logic [7:0] dev_d,
   input wire logic dev_oe,
   // strobes
   output logic as_o,
   output logic ds_o,
   output logic rw_o,
   output logic cs_n_o
);
   logic [7:0] host_d = 8'h00;
   logic host_oe = 1'b0;
   logic [7:0] last = 8'h00;
   // released bus shows a changing pattern, never a stale byte
   assign bus = dev_oe ? dev_d : host_oe ? host_d : ~last;
   always @(posedge clk) last <= bus;
   initial
   begin
      as_o = 1'b0;
      ds_o = 1'b1;
      rw_o = 1'b1;
      cs_n_o = 1'b1;
   end
   // 4 clocks per level so each one survives the synchroniser
   task automatic step();
      repeat (4) @(posedge clk);
   endtask
   task automatic idle();
      ds_o <= ~style;
   endtask
   // chip select left high here on purpose
   // bus left driven; the caller turns it around
   task automatic addr(input logic [7:0] a);
      @(posedge clk);
      host_d <= a;
      host_oe <= 1'b1;
      as_o <= 1'b1;
      step();
      as_o <= 1'b0;
      step();
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      addr(a);
      cs_n_o <= 1'b0;
      host_d <= d;
      rw_o <= 1'b0;
      if (style)
      begin
         ds_o <= 1'b1;
         step();
         ds_o <= 1'b0;
      end
      step();
      rw_o <= 1'b1;
      step();
      cs_n_o <= 1'b1;
      host_oe <= 1'b0;
   endtask
   // data strobe inverts from idle: a read in either style
   task automatic xfer(input logic cs_n, output logic [7:0] d,
                       output logic oe);
      @(posedge clk);
      cs_n_o <= cs_n;
      ds_o <= ~ds_o;
      step();
      @(negedge clk);
      d = bus;
      oe = dev_oe;
      @(posedge clk);
      ds_o <= ~ds_o;
      step();
      cs_n_o <= 1'b1;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d,
                     output logic oe);
      addr(a);
      host_oe <= 1'b0;
      xfer(1'b0, d, oe);
   endtask
endmodule

// >>> bench/rhb_core_bench.sv
// rhb_core_bench: self-checking bench for the rtc host bus core
// assumes the tick pin toggles every clock to make a second short
`timescale 1ns/1ns
module rhb_core_bench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic style = 1'b0;
   logic reset_pin_n = 1'b1;
   logic osc_tick = 1'b0;
   logic pg = 1'b1;
   logic ce_in_n = 1'b1;
   logic [7:0] bus, dout, d;
   logic oe, irq_out, irq_oe, wave, ce_out_n, as_s, ds_s, rw_s, cs_n;
   logic seen;
   int error_cnt = 0;
   int cmp_count = 0;
   int n;
   rhb_core dut (.clk(clk), .rst(rst), .mux_addr_data_in(bus),
      .mux_addr_data_out(dout), .mux_addr_data_oe(oe),
      .addr_strobe(as_s), .data_strobe(ds_s), .rw_strobe(rw_s),
      .chip_sel_n(cs_n), .bus_style_select(style),
      .reset_pin_n(reset_pin_n), .irq_out(irq_out), .irq_oe(irq_oe),
      .osc_tick(osc_tick), .wave_out(wave), .ram_power_good(pg),
      .ram_ce_in_n(ce_in_n), .ram_ce_out_n(ce_out_n));
   rhb_host host (.clk(clk), .style(style), .bus(bus), .dev_d(dout),
      .dev_oe(oe), .as_o(as_s), .ds_o(ds_s), .rw_o(rw_s),
      .cs_n_o(cs_n));
   initial
   begin
      forever #5 clk = ~clk;
   end
   always @(posedge clk) osc_tick <= ~osc_tick;
   task automatic test_done();
      if (error_cnt == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] exp,
                      input logic [7:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] m,
                      input logic [7:0] exp, input string what);
      host.rd(a, d, seen);
      chk(what, exp, d & m);
   endtask
   task automatic waves(output int c);
      logic w0;
      c = 0;
      w0 = wave;
      repeat (200)
      begin
         @(negedge clk);
         if (wave !== w0)
            c++;
         w0 = wave;
      end
      @(posedge clk);
   endtask
   initial
   begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      waves(n);
      chk("wave idle", 8'h00, 8'(n));
      host.wr(8'h0B, 8'h0A);
      rdc(8'h0B, 8'hFF, 8'h0A, "reg b");
      waves(n);
      chk("wave run", 8'h01, 8'(n >= 4));
      host.wr(8'h40, 8'hC3);
      rdc(8'h40, 8'hFF, 8'hC3, "storage");
      rdc(8'h0D, 8'hFF, 8'h80, "reg d");
      host.xfer(1'b1, d, seen);
      chk("oe deselected", 8'h00, 8'(seen));
      ce_in_n <= 1'b0;
      @(negedge clk);
      chk("ram ce", 8'h00, 8'(ce_out_n));
      @(posedge clk);
      pg <= 1'b0;
      repeat (4) @(negedge clk);
      chk("ram ce off", 8'h01, 8'(ce_out_n));
      @(posedge clk);
      pg <= 1'b1;
      ce_in_n <= 1'b1;
      host.wr(8'h0B, 8'h92);
      host.wr(8'h00, 8'h30);
      host.wr(8'h0B, 8'h12);
      n = 0;
      while (irq_oe !== 1'b1 && n < 70000)
      begin
         @(negedge clk);
         n++;
      end
      chk("irq raised", 8'h01, 8'(irq_oe));
      chk("irq level", 8'h00, 8'(irq_out));
      @(posedge clk);
      rdc(8'h0C, 8'h90, 8'h90, "flags");
      @(negedge clk);
      chk("irq released", 8'h00, 8'(irq_oe));
      @(posedge clk);
      rdc(8'h00, 8'hFF, 8'h31, "seconds");
      rdc(8'h0C, 8'h90, 8'h00, "flags clear");
      host.wr(8'h0B, 8'h7A);
      reset_pin_n <= 1'b0;
      host.rd(8'h0B, d, seen);
      chk("oe in reset", 8'h00, 8'(seen));
      reset_pin_n <= 1'b1;
      rdc(8'h0B, 8'hFF, 8'h02, "reg b cleared");
      // bus style only moves while the core is held in reset
      rst <= 1'b1;
      style <= 1'b1;
      repeat (16) @(posedge clk);
      host.idle();
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      host.wr(8'h41, 8'h5A);
      rdc(8'h41, 8'hFF, 8'h5A, "dir storage");
      host.xfer(1'b1, d, seen);
      chk("dir deselected", 8'h00, 8'(seen));
      test_done();
   end
   initial
   begin
      repeat (90000) @(posedge clk);
      error_cnt++;
      test_done();
   end
endmodule
